// ### design/hmr_halt_mode_release_control.sv
// Operation
// - CPU-only halt stops the CPU; selected peripherals keep running.
// - Oscillator-only halt stops system clock; oscillator, RTC, melody run.
// - Full stop halts all circuits including the oscillator.
// - Wake requests sampled without system clock; exit is synchronous.
// - Wake at level not below mask leaves halt and services it.
// - Masked pin, key, alarm or RTC wake resumes after halt instruction.
// - Internal irqs end only CPU-only halt when enabled; alarm/RTC never stop.
// - Non-maskable requests carry level seven and always service.
// - Wakes from full stop complete warm-up before release.
// - Level-detect requests are treated as non-maskable here.
// - Reset ends any halt and restores the initial state.
// - No system clock after stop until warm-up count elapses.
// - Release clock select picks fast or slow restart clock after stop.
// - Warm-up select codes give 2^8, 2^14 or 2^16 cycles.
// - Idle buffers use both drive bits; stop uses stop-drive bit.
// - Drive bits map to buffer conditions A or B per mode.
// - Wake during halt instruction releases without clock-mode change.
// - Masked wakes keep the source request flag set after resuming.
// - Wake during entry is held pending and arbitrated later.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module hmr_halt_mode_release_control
	import hmr_pkg::*;
#(
	parameter logic [16:0] WARM_14 = 17'h04000,
	parameter logic [16:0] WARM_16 = 17'h10000
) (
	input  wire logic                   SYS_CLK_IN,
	input  wire logic                   RST_IN,
	input  wire logic                   PSEL_IN,
	input  wire logic                   PENABLE_IN,
	input  wire logic                   PWRITE_IN,
	input  wire logic [7:0]             PADDR_IN,
	input  wire logic [31:0]            PWDATA_IN,
	output logic      [31:0]            PRDATA_OUT,
	output logic                        PREADY_OUT,
	output logic                        PSLVERR_OUT,
	input  wire logic                   HALT_REQ_IN,
	input  wire logic [2:0]             MASK_LEVEL_IN,
	input  wire logic [2:0]             WAKE_LEVEL_IN,
	input  wire hmr_wake_t              WAKE_PINS_IN,
	input  wire logic                   WATCHDOG_IRQ_IN,
	input  wire logic [3:0]             TIMER_IRQS_IN,
	input  wire logic [1:0]             SERIAL_RECEIVE_IRQS_IN,
	input  wire logic                   DISPLAY_IRQ_IN,
	output logic                        CPU_RUN_OUT,
	output logic                        SYS_CLK_EN_OUT,
	output logic                        HIGH_OSC_EN_OUT,
	output logic                        LOW_OSC_EN_OUT,
	output logic                        RTC_MLD_RUN_OUT,
	output logic [HMR_NPERIPH-1:0]      PERIPH_RUN_OUT,
	output logic                        SLOW_CLK_SEL_OUT,
	output logic                        PIN_HOLD_OUT,
	output logic                        BUF_COND_B_OUT,
	output logic                        SERVICE_IRQ_OUT,
	output logic                        RESUME_NEXT_OUT,
	output logic                        KEEP_FLAG_OUT,
	output logic                        HELD_WAKE_OUT
);

	// ==========================================================
	// Wake pin synchronisers
	hmr_wake_t               sync_a;
	hmr_wake_t               sync_b;
	hmr_wake_t               any_prev;

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			sync_a   <= '0;
			sync_b   <= '0;
			any_prev <= '0;
		end else begin
			sync_a   <= WAKE_PINS_IN;
			sync_b   <= sync_a;
			any_prev <= sync_b;
		end
	end

	// ==========================================================
	// Wake classification
	hmr_ctrl_t               ctrl;
	logic [HMR_NPERIPH-1:0]  run_sel;
	logic                    nmi_class;
	logic                    pin_wake;
	logic                    alarm_wake;
	logic                    int_wake;
	logic                    enabled;
	logic                    wake_rise;

	always_comb begin
		nmi_class  = sync_b.nmi | (|sync_b.level_detect_irqs);
		pin_wake   = (|sync_b.external_pin_irqs) | sync_b.key_wake_irq;
		alarm_wake = (|sync_b.alarm_irqs) | sync_b.realtime_clock_irq;
		int_wake   = WATCHDOG_IRQ_IN | (|TIMER_IRQS_IN) |
			(|SERIAL_RECEIVE_IRQS_IN) | DISPLAY_IRQ_IN;
		enabled    = (WAKE_LEVEL_IN >= MASK_LEVEL_IN) ||
			(HMR_NMI_LEVEL >= MASK_LEVEL_IN && nmi_class);
		wake_rise  = |(sync_b & ~any_prev);
	end

	// ==========================================================
	// Sequencer
	hmr_state_t              state;
	hmr_state_t              next_state;
	logic [2:0]              enter_cnt;
	logic [2:0]              next_enter_cnt;
	logic [HMR_CNT_W-1:0]    warm_cnt;
	logic [HMR_CNT_W-1:0]    next_warm_cnt;
	logic [1:0]              mode;
	logic [1:0]              next_mode;
	logic                    pend;
	logic                    next_pend;
	logic                    warm_service;
	logic                    next_warm_service;
	logic                    slow;
	logic                    next_slow;
	logic                    next_service;
	logic                    next_resume;
	logic                    next_keep;
	logic                    mode_wake;
	logic                    wake_serv;
	logic [HMR_CNT_W-1:0]    warm_load;

	always_comb begin
		case (ctrl.warmup_count_select)
			HMR_WU_14: warm_load = WARM_14;
			HMR_WU_16: warm_load = WARM_16;
			default:   warm_load = HMR_WARM_8;
		endcase
		case (state)
			HMR_HALT_CPU: mode_wake = nmi_class | pin_wake | alarm_wake |
				(int_wake & enabled);
			HMR_HALT_STOP: mode_wake = nmi_class | pin_wake;
			default: mode_wake = nmi_class | pin_wake |
				(alarm_wake & (mode != HMR_MODE_STOP));
		endcase
		wake_serv = nmi_class | enabled;
	end

	always_comb begin
		next_state        = state;
		next_enter_cnt    = enter_cnt;
		next_warm_cnt     = warm_cnt;
		next_mode         = mode;
		next_pend         = pend;
		next_warm_service = warm_service;
		next_slow         = slow;
		next_service      = 1'b0;
		next_resume       = 1'b0;
		next_keep         = 1'b0;
		case (state)
			HMR_RUN: begin
				if (HALT_REQ_IN) begin
					next_mode = ctrl.halt_mode_select;
					if (ctrl.halt_mode_select == HMR_MODE_CPU) begin
						next_state = HMR_HALT_CPU;
					end else if (ctrl.halt_mode_select == HMR_MODE_OSC ||
						ctrl.halt_mode_select == HMR_MODE_STOP) begin
						next_state     = HMR_ENTER;
						next_enter_cnt = '0;
					end
				end
			end
			HMR_ENTER: begin
				if (enter_cnt == '0 && wake_serv && mode_wake) begin
					next_state   = HMR_RUN;
					next_service = 1'b1;
				end else begin
					if (mode_wake) begin
						next_pend = 1'b1;
					end
					next_enter_cnt = enter_cnt + 3'h1;
					if (enter_cnt == HMR_ENTER_LAST) begin
						next_state = (mode == HMR_MODE_STOP) ?
							HMR_HALT_STOP : HMR_HALT_OSC;
					end
				end
			end
			HMR_HALT_CPU, HMR_HALT_OSC: begin
				if (mode_wake && (!pend || wake_rise)) begin
					next_state   = HMR_RUN;
					next_service = wake_serv;
					next_resume  = ~wake_serv;
					next_keep    = ~wake_serv;
					next_pend    = 1'b0;
				end
			end
			HMR_HALT_STOP: begin
				if (mode_wake && (!pend || wake_rise)) begin
					next_state        = HMR_WARMUP;
					next_warm_cnt     = warm_load;
					next_warm_service = wake_serv;
				end
			end
			HMR_WARMUP: begin
				next_warm_cnt = warm_cnt - HMR_CNT_ONE;
				if (warm_cnt <= HMR_CNT_ONE) begin
					next_state   = HMR_RUN;
					next_slow    = ctrl.release_slow;
					next_service = warm_service;
					next_resume  = ~warm_service;
					next_keep    = ~warm_service;
					next_pend    = 1'b0;
				end
			end
			default: next_state = HMR_RUN;
		endcase
	end

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state           <= HMR_RUN;
			enter_cnt       <= '0;
			warm_cnt        <= '0;
			mode            <= HMR_MODE_CPU;
			pend            <= 1'b0;
			warm_service    <= 1'b0;
			slow            <= 1'b0;
			SERVICE_IRQ_OUT <= 1'b0;
			RESUME_NEXT_OUT <= 1'b0;
			KEEP_FLAG_OUT   <= 1'b0;
		end else begin
			state           <= next_state;
			enter_cnt       <= next_enter_cnt;
			warm_cnt        <= next_warm_cnt;
			mode            <= next_mode;
			pend            <= next_pend;
			warm_service    <= next_warm_service;
			slow            <= next_slow;
			SERVICE_IRQ_OUT <= next_service;
			RESUME_NEXT_OUT <= next_resume;
			KEEP_FLAG_OUT   <= next_keep;
		end
	end

	// ==========================================================
	// Clock, power and pin outputs
	logic                    next_cpu;
	logic                    next_sysclk;
	logic                    next_hosc;
	logic                    next_losc;
	logic                    next_rtc;
	logic [HMR_NPERIPH-1:0]  next_periph;
	logic                    next_hold;
	logic                    next_condb;

	always_comb begin
		next_cpu    = 1'b0;
		next_sysclk = 1'b1;
		next_hosc   = ctrl.high_osc_enable;
		next_losc   = ctrl.low_osc_enable;
		next_rtc    = 1'b1;
		next_periph = '1;
		next_hold   = 1'b1;
		next_condb  = 1'b0;
		case (next_state)
			HMR_RUN: begin
				next_cpu  = 1'b1;
				next_hold = 1'b0;
			end
			HMR_HALT_CPU: next_periph = run_sel;
			HMR_HALT_OSC: begin
				next_sysclk = 1'b0;
				next_periph = '0;
				next_condb  = ~(ctrl.idle_drive_sel &
					~ctrl.stop_drive);
			end
			HMR_HALT_STOP, HMR_WARMUP: begin
				next_sysclk = 1'b0;
				next_periph = '0;
				next_rtc    = 1'b0;
				next_hosc   = (next_state == HMR_WARMUP) &
					~ctrl.release_slow;
				next_losc   = (next_state == HMR_WARMUP) &
					ctrl.release_slow;
				next_condb  = ctrl.stop_drive;
			end
			default: next_periph = '1;
		endcase
	end

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			CPU_RUN_OUT      <= 1'b1;
			SYS_CLK_EN_OUT   <= 1'b1;
			HIGH_OSC_EN_OUT  <= 1'b1;
			LOW_OSC_EN_OUT   <= 1'b1;
			RTC_MLD_RUN_OUT  <= 1'b1;
			PERIPH_RUN_OUT   <= '1;
			SLOW_CLK_SEL_OUT <= 1'b0;
			PIN_HOLD_OUT     <= 1'b0;
			BUF_COND_B_OUT   <= 1'b0;
			HELD_WAKE_OUT    <= 1'b0;
		end else begin
			CPU_RUN_OUT      <= next_cpu;
			SYS_CLK_EN_OUT   <= next_sysclk;
			HIGH_OSC_EN_OUT  <= next_hosc;
			LOW_OSC_EN_OUT   <= next_losc;
			RTC_MLD_RUN_OUT  <= next_rtc;
			PERIPH_RUN_OUT   <= next_periph;
			SLOW_CLK_SEL_OUT <= next_slow;
			PIN_HOLD_OUT     <= next_hold;
			BUF_COND_B_OUT   <= next_condb;
			HELD_WAKE_OUT    <= next_pend;
		end
	end

	// ==========================================================
	// APB register slave
	hmr_ctrl_t               next_ctrl;
	logic [HMR_NPERIPH-1:0]  next_run_sel;
	logic [31:0]             next_prdata;
	logic                    next_pready;
	logic                    next_pslverr;
	logic                    setup;
	logic                    wr_go;
	logic                    mapped;

	always_comb begin
		setup        = PSEL_IN & ~PENABLE_IN;
		wr_go        = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
		mapped       = (PADDR_IN == HMR_ADDR_CTRL) ||
			(PADDR_IN == HMR_ADDR_RUNSEL) || (PADDR_IN == HMR_ADDR_STATUS);
		next_ctrl    = ctrl;
		next_run_sel = run_sel;
		next_prdata  = PRDATA_OUT;
		next_pready  = setup;
		next_pslverr = setup & ~mapped;
		if (wr_go && !PSLVERR_OUT) begin
			if (PADDR_IN == HMR_ADDR_CTRL) begin
				next_ctrl = PWDATA_IN[$bits(hmr_ctrl_t)-1:0];
			end else if (PADDR_IN == HMR_ADDR_RUNSEL) begin
				next_run_sel = PWDATA_IN[HMR_NPERIPH-1:0];
			end
		end
		if (setup) begin
			case (PADDR_IN)
				HMR_ADDR_CTRL:   next_prdata = {23'h0, ctrl};
				HMR_ADDR_RUNSEL: next_prdata = {27'h0, run_sel};
				HMR_ADDR_STATUS: next_prdata = {27'h0, slow, pend,
					state};
				default:         next_prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ctrl        <= HMR_CTRL_RST;
			run_sel     <= HMR_RUNSEL_RST;
			PRDATA_OUT  <= 32'h0;
			PREADY_OUT  <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end else begin
			ctrl        <= next_ctrl;
			run_sel     <= next_run_sel;
			PRDATA_OUT  <= next_prdata;
			PREADY_OUT  <= next_pready;
			PSLVERR_OUT <= next_pslverr;
		end
	end

endmodule

// ### inc/hmr_pkg.sv
package hmr_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] HMR_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] HMR_ADDR_RUNSEL = 8'h04;
	localparam logic [7:0] HMR_ADDR_STATUS = 8'h08;

	// ==========================================================
	// Field codes
	localparam logic [1:0] HMR_MODE_CPU  = 2'h0;
	localparam logic [1:0] HMR_MODE_STOP = 2'h1;
	localparam logic [1:0] HMR_MODE_OSC  = 2'h2;
	localparam logic [1:0] HMR_WU_8      = 2'h1;
	localparam logic [1:0] HMR_WU_14     = 2'h2;
	localparam logic [1:0] HMR_WU_16     = 2'h3;
	localparam logic [2:0] HMR_NMI_LEVEL = 3'h7;

	// ==========================================================
	// Widths, counts and reset values
	localparam int         HMR_NASYNC     = 15;
	localparam int         HMR_NPERIPH    = 5;
	localparam int         HMR_CNT_W      = 17;
	localparam int         HMR_ENTER_CYC  = 5;
	localparam logic [2:0] HMR_ENTER_LAST = 3'h4;
	localparam logic [16:0] HMR_WARM_8    = 17'h00100;
	localparam logic [16:0] HMR_CNT_ONE   = 17'h00001;
	localparam logic [4:0] HMR_RUNSEL_RST = 5'h00;

	// ==========================================================
	// Control register layout
	typedef struct packed {
		logic       stop_drive;
		logic       idle_drive_sel;
		logic       low_osc_enable;
		logic       high_osc_enable;
		logic       release_slow;
		logic [1:0] warmup_count_select;
		logic [1:0] halt_mode_select;
	} hmr_ctrl_t;

	localparam hmr_ctrl_t HMR_CTRL_RST = '{
		stop_drive:          1'b0,
		idle_drive_sel:      1'b0,
		low_osc_enable:      1'b1,
		high_osc_enable:     1'b1,
		release_slow:        1'b0,
		warmup_count_select: 2'h3,
		halt_mode_select:    2'h3
	};

	// Asynchronous wake pins: bit 0 nmi, 4:1 external, 5 key,
	// 10:6 alarm, 11 realtime clock, 14:12 level detect.
	typedef struct packed {
		logic [2:0] level_detect_irqs;
		logic       realtime_clock_irq;
		logic [4:0] alarm_irqs;
		logic       key_wake_irq;
		logic [3:0] external_pin_irqs;
		logic       nmi;
	} hmr_wake_t;

	typedef enum logic [2:0] {
		HMR_RUN,
		HMR_ENTER,
		HMR_HALT_CPU,
		HMR_HALT_OSC,
		HMR_HALT_STOP,
		HMR_WARMUP
	} hmr_state_t;

endpackage

// ### test/hmr_release_sva.sv
`timescale 1ns/10ps
// ==========================================================
// Halt entry and release checks.
module hmr_release_sva
	import hmr_pkg::*;
#(
	parameter logic [16:0] WARM_14 = 17'h04000,
	parameter logic [16:0] WARM_16 = 17'h10000
) (
	input  wire logic SYS_CLK_IN,
	input  wire logic RST_IN,
	input  wire logic HALT_REQ_IN,
	input  wire logic CPU_RUN_OUT,
	input  wire logic SYS_CLK_EN_OUT,
	input  wire logic HIGH_OSC_EN_OUT,
	input  wire logic LOW_OSC_EN_OUT,
	input  wire logic RTC_MLD_RUN_OUT,
	input  wire logic PIN_HOLD_OUT,
	input  wire logic SERVICE_IRQ_OUT,
	input  wire logic RESUME_NEXT_OUT,
	input  wire logic KEEP_FLAG_OUT
);
	localparam int W_A  = (WARM_14 < WARM_16) ? WARM_14 : WARM_16;
	localparam int WMIN = ((W_A < 256) ? W_A : 256) - 2;
	logic [16:0]	wcnt;
	logic [16:0]	next_wcnt;
	logic		from_stop;
	logic		next_from_stop;
	wire		osc_off = !HIGH_OSC_EN_OUT && !LOW_OSC_EN_OUT;

	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (RST_IN);

	// Counts clock-gated cycles since the oscillators came back.
	always_comb begin
		next_from_stop = from_stop;
		next_wcnt = wcnt;
		if (osc_off) begin
			next_from_stop = 1'b1;
			next_wcnt = 17'h00000;
		end else if (SYS_CLK_EN_OUT) begin
			next_from_stop = 1'b0;
		end else if (wcnt != 17'h1ffff) begin
			next_wcnt = wcnt + 17'h00001;
		end
	end

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			from_stop <= 1'b0;
			wcnt <= 17'h00000;
		end else begin
			from_stop <= next_from_stop;
			wcnt <= next_wcnt;
		end
	end

	sequence release_s;
		SERVICE_IRQ_OUT || RESUME_NEXT_OUT;
	endsequence

	reset_state_a: assert property ($fell(RST_IN) |-> CPU_RUN_OUT &&
		SYS_CLK_EN_OUT && RTC_MLD_RUN_OUT && !PIN_HOLD_OUT)
		else $error("state after reset wrong");
	cpu_stop_a: assert property ($fell(CPU_RUN_OUT) |-> $past(HALT_REQ_IN))
		else $error("cpu stopped without halt request");
	stop_all_a: assert property (osc_off |-> !SYS_CLK_EN_OUT &&
		!RTC_MLD_RUN_OUT && !CPU_RUN_OUT)
		else $error("circuit running in full stop");
	osc_halt_a: assert property (!SYS_CLK_EN_OUT && RTC_MLD_RUN_OUT |->
		!CPU_RUN_OUT && (HIGH_OSC_EN_OUT || LOW_OSC_EN_OUT))
		else $error("oscillator halt state wrong");
	release_run_a: assert property (release_s |-> CPU_RUN_OUT)
		else $error("release without cpu restart");
	service_only_a: assert property (SERVICE_IRQ_OUT |->
		!RESUME_NEXT_OUT && !KEEP_FLAG_OUT)
		else $error("service and resume together");
	keep_flag_a: assert property (RESUME_NEXT_OUT |-> KEEP_FLAG_OUT)
		else $error("request flag not kept on resume");
	warm_time_a: assert property ($rose(SYS_CLK_EN_OUT) && from_stop |->
		wcnt >= WMIN)
		else $error("clock restarted before warm-up");
endmodule

bind hmr_halt_mode_release_control hmr_release_sva #(
	.WARM_14(WARM_14),
	.WARM_16(WARM_16)
) chk_u (.*);

// ### test/hmr_wake_src.sv
`timescale 1ns/10ps
// ==========================================================
// Wake sources: a raised request stands until it is taken.
module hmr_wake_src
	import hmr_pkg::*;
(
	input  wire logic	clk_in,
	input  wire logic	rst_in,
	input  wire hmr_wake_t	raise_in,
	input  wire logic	done_in,
	output hmr_wake_t	pins_out
);
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			pins_out <= '0;
		else if (done_in)
			pins_out <= '0;
		else
			pins_out <= pins_out | raise_in;
	end
endmodule

// ### test/test_halt_mode_release_control.sv
`timescale 1ns/10ps
// ==========================================================
// Bench for the halt mode release control.
module test_halt_mode_release_control
	import hmr_pkg::*;
;
	localparam logic [16:0] W14 = 17'h00014;
	localparam logic [16:0] W16 = 17'h00028;
	logic		SYS_CLK_IN = 0, RST_IN = 1, HALT_REQ_IN = 0;
	logic		PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0;
	logic		WATCHDOG_IRQ_IN = 0, DISPLAY_IRQ_IN = 0;
	logic [7:0]	PADDR_IN = 8'h00;
	logic [31:0]	PWDATA_IN = 32'h0, PRDATA_OUT, q;
	logic [2:0]	MASK_LEVEL_IN = 3'h0, WAKE_LEVEL_IN = 3'h0;
	logic [3:0]	TIMER_IRQS_IN = 4'h0;
	logic [1:0]	SERIAL_RECEIVE_IRQS_IN = 2'h0;
	hmr_wake_t	WAKE_PINS_IN, raise = '0;
	logic [4:0]	PERIPH_RUN_OUT, rs;
	logic		PREADY_OUT, PSLVERR_OUT, CPU_RUN_OUT, SYS_CLK_EN_OUT;
	logic		HIGH_OSC_EN_OUT, LOW_OSC_EN_OUT, RTC_MLD_RUN_OUT;
	logic		SLOW_CLK_SEL_OUT, PIN_HOLD_OUT, BUF_COND_B_OUT;
	logic		SERVICE_IRQ_OUT, RESUME_NEXT_OUT, KEEP_FLAG_OUT;
	logic		HELD_WAKE_OUT, e, s, r, k, sl;
	int		fail_count = 0, total_checks = 0, n, ne;

	hmr_halt_mode_release_control #(.WARM_14(W14), .WARM_16(W16)) dut_u (.*);
	hmr_wake_src src_u (.clk_in(SYS_CLK_IN), .rst_in(RST_IN),
		.raise_in(raise), .done_in(SERVICE_IRQ_OUT | RESUME_NEXT_OUT),
		.pins_out(WAKE_PINS_IN));

	always #10 SYS_CLK_IN = ~SYS_CLK_IN;

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge SYS_CLK_IN);
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		tick(1);
		PSEL_IN <= 1'b1;
		PWRITE_IN <= w;
		PADDR_IN <= a;
		PWDATA_IN <= d;
		tick(1);
		PENABLE_IN <= 1'b1;
		i = 0;
		do begin
			tick(1);
			i++;
		end while (PREADY_OUT !== 1'b1 && i < 20);
		if (PREADY_OUT !== 1'b1) begin
			fail_count++;
			test_done();
		end
		q = PRDATA_OUT;
		e = PSLVERR_OUT;
		PSEL_IN <= 1'b0;
		PENABLE_IN <= 1'b0;
	endtask

	task automatic enter(input logic [8:0] v, input int t);
		apb(1'b1, HMR_ADDR_CTRL, {23'h0, v});
		tick(1);
		HALT_REQ_IN <= 1'b1;
		tick(1);
		HALT_REQ_IN <= 1'b0;
		tick(t);
	endtask

	task automatic wake(input logic [14:0] p);
		tick(1);
		raise <= p;
		tick(1);
		raise <= '0;
	endtask

	task automatic wait_run;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (CPU_RUN_OUT !== 1'b1 && n < 1000);
		s = SERVICE_IRQ_OUT;
		r = RESUME_NEXT_OUT;
		k = KEEP_FLAG_OUT;
		if (CPU_RUN_OUT !== 1'b1) begin
			fail_count++;
			test_done();
		end
	endtask

	initial begin
		void'($urandom(89));
		tick(10);
		RST_IN <= 1'b0;
		apb(1'b0, HMR_ADDR_CTRL, 32'h0);
		chk(q, 32'h0000006f);
		apb(1'b1, 8'h0c, 32'hffffffff);
		chk(e, 1'b1);
		$display("test registers done");
		rs = $urandom;
		apb(1'b1, HMR_ADDR_RUNSEL, {27'h0, rs});
		enter(9'h06c | HMR_MODE_CPU, 8);
		chk(CPU_RUN_OUT, 1'b0);
		chk(SYS_CLK_EN_OUT, 1'b1);
		chk(PERIPH_RUN_OUT, rs);
		MASK_LEVEL_IN <= 3'h3;
		WAKE_LEVEL_IN <= 3'h3 + 3'($urandom % 4);
		{DISPLAY_IRQ_IN, SERIAL_RECEIVE_IRQS_IN, TIMER_IRQS_IN,
			WATCHDOG_IRQ_IN} <= 8'h01 << ($urandom % 8);
		wait_run;
		chk({s, r}, 2'b10);
		$display("test cpu halt done");
		for (int d = 0; d < 3; d++) begin
			enter({d[1:0], 7'h6c} | HMR_MODE_OSC, 8);
			chk({SYS_CLK_EN_OUT, RTC_MLD_RUN_OUT}, 2'b01);
			chk(HIGH_OSC_EN_OUT & LOW_OSC_EN_OUT, 1'b1);
			chk(BUF_COND_B_OUT, d != 1);
			{DISPLAY_IRQ_IN, SERIAL_RECEIVE_IRQS_IN, TIMER_IRQS_IN,
				WATCHDOG_IRQ_IN} <= 8'hff;
			tick(6);
			chk(CPU_RUN_OUT, 1'b0);
			{DISPLAY_IRQ_IN, SERIAL_RECEIVE_IRQS_IN, TIMER_IRQS_IN,
				WATCHDOG_IRQ_IN} <= 8'h00;
			MASK_LEVEL_IN <= 3'h6;
			WAKE_LEVEL_IN <= 3'h2;
			wake(15'h0002 << ($urandom % 11));
			wait_run;
			chk({s, r, k}, 3'b011);
		end
		$display("test oscillator halt done");
		for (int w = 1; w < 4; w++) begin
			sl = $urandom;
			enter({w[0], 1'b0, 2'b11, sl, w[1:0], 2'b00} | HMR_MODE_STOP,
				8);
			chk({HIGH_OSC_EN_OUT, LOW_OSC_EN_OUT, SYS_CLK_EN_OUT}, 3'h0);
			chk(BUF_COND_B_OUT, w[0]);
			wake(15'h0040 << ($urandom % 6));
			tick(6);
			chk(CPU_RUN_OUT, 1'b0);
			MASK_LEVEL_IN <= 3'h7;
			wake(($urandom % 2) ? 15'h0001 : 15'h1000 << ($urandom % 3));
			wait_run;
			ne = (w == 2) ? W14 : (w == 3) ? W16 : 256;
			chk(n >= ne && n <= ne + 6, 1'b1);
			chk(s, 1'b1);
			tick(1);
			chk(SLOW_CLK_SEL_OUT, sl);
		end
		$display("test full stop done");
		MASK_LEVEL_IN <= 3'h1;
		WAKE_LEVEL_IN <= 3'h5;
		enter(9'h06c | HMR_MODE_OSC, 0);
		wake(15'h0002);
		tick(8);
		chk({HELD_WAKE_OUT, CPU_RUN_OUT}, 2'b10);
		wake(15'h4000);
		wait_run;
		chk(s, 1'b1);
		wake(15'h0002);
		tick(4);
		enter(9'h06c | HMR_MODE_OSC, 0);
		wait_run;
		chk({s, SYS_CLK_EN_OUT}, 2'b11);
		$display("test entry wake done");
		enter(9'h06c | HMR_MODE_CPU, 4);
		RST_IN <= 1'b1;
		tick(2);
		chk({CPU_RUN_OUT, PIN_HOLD_OUT}, 2'b10);
		RST_IN <= 1'b0;
		apb(1'b0, HMR_ADDR_CTRL, 32'h0);
		chk(q, 32'h0000006f);
		$display("test reset done");
		test_done();
	end
endmodule
